// File: logic/aie_consts.vh
// Constants for the converter interrupt-enable bank.
// Assumes inclusion by the bank's design and verification files.
`ifndef AIE_CONSTS_VH
`define AIE_CONSTS_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define AIE_OFF_DIRECT    12'h300
`define AIE_OFF_SET       12'h304
`define AIE_OFF_CLEAR     12'h308
`define AIE_OFF_EVENTS    12'h30c
`define AIE_OFF_LIMIT_BASE 12'h310

// ----------------------------------------
// Field layout and reset values
// ----------------------------------------
`define AIE_NUM_EVENTS    22
`define AIE_BIT_STARTED   0
`define AIE_BIT_BUFEND    1
`define AIE_BIT_CONVDONE  2
`define AIE_BIT_RESULT    3
`define AIE_BIT_CALDONE   4
`define AIE_BIT_STOPPED   5
`define AIE_BIT_LIMIT0    6
`define AIE_NUM_CHANNELS  8
`define AIE_RESULT_W      16
`define AIE_ENABLE_RESET  22'h000000
`define AIE_LIMIT_RESET   32'h7fff8000
`define AIE_RESP_OKAY     2'b00
`define AIE_RESP_SLVERR   2'b10

`endif

// File: logic/aie_limit_check.v
// Limit comparator for one converter channel.
// Assumes a signed result and a strobe that marks each new result.
`timescale 1ns/1ps
`default_nettype none
`include "aie_consts.vh"

module aie_limit_check
(
  // Clock and reset
  input  wire                       clk,
  input  wire                       reset_n,
  // Result strobe
  input  wire                       resultValid,
  input  wire [`AIE_RESULT_W-1:0]   resultValue,
  // Limits
  input  wire [`AIE_RESULT_W-1:0]   limitHigh,
  input  wire [`AIE_RESULT_W-1:0]   limitLow,
  // Event pulses
  output reg                        highEvent,
  output reg                        lowEvent
);

  // Compare on each new result; signed since results may be negative
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      highEvent <= 1'b0;
      lowEvent  <= 1'b0;
    end
    else
    begin
      highEvent <= resultValid && ($signed(resultValue) >= $signed(limitHigh));
      lowEvent  <= resultValid && ($signed(resultValue) <= $signed(limitLow));
    end
  end

endmodule
`default_nettype wire

// File: logic/aie_enable_bank.v
// Interrupt-enable bank of the converter peripheral with AXI4-Lite slave.
// Assumes event pulses synchronous to clk from the converter sequencer.
// Assumes one write and one read outstanding; later requests wait.
// Limit registers are extra: channel windows for the limit events.
//
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "aie_consts.vh"

module aie_enable_bank
(
  // Clock and reset
  input  wire                         clk,
  input  wire                         reset_n,
  // AXI4-Lite write address
  input  wire [11:0]                  s_axi_awaddr,
  input  wire                         s_axi_awvalid,
  output reg                          s_axi_awready,
  // AXI4-Lite write data
  input  wire [31:0]                  s_axi_wdata,
  input  wire [3:0]                   s_axi_wstrb,
  input  wire                         s_axi_wvalid,
  output reg                          s_axi_wready,
  // AXI4-Lite write response
  output reg  [1:0]                   s_axi_bresp,
  output reg                          s_axi_bvalid,
  input  wire                         s_axi_bready,
  // AXI4-Lite read address
  input  wire [11:0]                  s_axi_araddr,
  input  wire                         s_axi_arvalid,
  output reg                          s_axi_arready,
  // AXI4-Lite read data
  output reg  [31:0]                  s_axi_rdata,
  output reg  [1:0]                   s_axi_rresp,
  output reg                          s_axi_rvalid,
  input  wire                         s_axi_rready,
  // Sequencing event pulses
  input  wire                         startedEvent,
  input  wire                         bufferEndEvent,
  input  wire                         conversionDoneEvent,
  input  wire                         resultReadyEvent,
  input  wire                         calibrationCompleteEvent,
  input  wire                         stoppedEvent,
  // Channel results for limit monitoring
  input  wire                         resultValid,
  input  wire [2:0]                   resultChannel,
  input  wire [`AIE_RESULT_W-1:0]     resultValue,
  // Interrupt request
  output reg                          irq
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  localparam N = `AIE_NUM_EVENTS;
  localparam NCH = `AIE_NUM_CHANNELS;

  // Enable, flag and limit state
  reg  [N-1:0]            irqEnableDirect_reg;
  reg  [N-1:0]            irqEnableDirect_next;
  reg  [N-1:0]            eventFlag_reg;
  reg  [N-1:0]            eventFlag_next;
  reg  [31:0]             limit_reg [0:NCH-1];
  // Write channel holding registers
  reg  [11:0]             awAddr_reg;
  reg                     awHave_reg;
  reg  [31:0]             wData_reg;
  reg  [3:0]              wStrb_reg;
  reg                     wHave_reg;
  // Combinational helpers
  wire [N-1:0]            eventPulse;
  wire [2*NCH-1:0]        limitPulse;
  wire [NCH-1:0]          chanSelect;
  wire [31:0]             directMerged;
  wire [3:0]              limitWrIdx;
  wire [3:0]              limitRdIdx;
  wire                    doWrite;
  wire [31:0]             wMasked;
  reg  [31:0]             readData;
  reg                     readOk;
  integer                 i;

  // Merge byte-lane strobes into a bit mask over old data
  // Lanes left low keep the old bits, so partial writes are safe
  function [31:0] apply_strobe;
    input [31:0] oldVal;
    input [31:0] newVal;
    input [3:0]  strb;
    integer k;
    begin
      for (k = 0; k < 4; k = k + 1)
        apply_strobe[8*k +: 8] = strb[k] ? newVal[8*k +: 8] : oldVal[8*k +: 8];
    end
  endfunction

  // Index of a limit register, or NCH when the address is not one
  // Index counted from the block base; raw address bits would rotate channels
  function [3:0] limit_index;
    input [11:0] addr;
    reg   [11:0] offset;
    begin
      offset = addr - `AIE_OFF_LIMIT_BASE;
      if (addr >= `AIE_OFF_LIMIT_BASE && addr < `AIE_OFF_LIMIT_BASE + 12'h020
          && addr[1:0] == 2'b00)
        limit_index = {1'b0, offset[4:2]};
      else
        limit_index = 4'h8;
    end
  endfunction

  // True for every address that answers OKAY; the rest get SLVERR
  function is_mapped;
    input [11:0] addr;
    begin
      case (addr)
        `AIE_OFF_DIRECT, `AIE_OFF_SET, `AIE_OFF_CLEAR, `AIE_OFF_EVENTS:
          is_mapped = 1'b1;
        default:
          is_mapped = (limit_index(addr) < NCH);
      endcase
    end
  endfunction

  // ----------------------------------------
  // Limit comparators, one per channel
  // ----------------------------------------
  // One-hot channel select; a shift avoids comparing a 3-bit field to a genvar
  assign chanSelect = {{(NCH-1){1'b0}}, 1'b1} << resultChannel;

  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1)
    begin : gen_limit
      // Each comparator sees every result but acts only on its own strobe
      aie_limit_check u_limit
      (
        .clk         (clk),
        .reset_n     (reset_n),
        .resultValid (resultValid && chanSelect[g]),
        .resultValue (resultValue),
        .limitHigh   (limit_reg[g][31:16]),
        .limitLow    (limit_reg[g][15:0]),
        .highEvent   (limitPulse[2*g]),
        .lowEvent    (limitPulse[2*g+1])
      );
    end
  endgenerate

  // Event vector layout
  // Limit pulses fill bits 6 up, high before low for each channel
  assign eventPulse[`AIE_BIT_STARTED]  = startedEvent;
  assign eventPulse[`AIE_BIT_BUFEND]   = bufferEndEvent;
  assign eventPulse[`AIE_BIT_CONVDONE] = conversionDoneEvent;
  assign eventPulse[`AIE_BIT_RESULT]   = resultReadyEvent;
  assign eventPulse[`AIE_BIT_CALDONE]  = calibrationCompleteEvent;
  assign eventPulse[`AIE_BIT_STOPPED]  = stoppedEvent;
  assign eventPulse[N-1:`AIE_BIT_LIMIT0] = limitPulse;

  // ----------------------------------------
  // Write channel
  // ----------------------------------------
  // A write commits only once the previous response has been taken
  assign doWrite = awHave_reg && wHave_reg && !s_axi_bvalid;
  assign wMasked = apply_strobe(32'h00000000, wData_reg, wStrb_reg);
  assign directMerged = apply_strobe({10'h000, irqEnableDirect_reg}, wData_reg, wStrb_reg);
  assign limitWrIdx = limit_index(awAddr_reg);

  // Address and data taken independently, in either order
  // A second address waits until the held one has been committed
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      awHave_reg    <= 1'b0;
      wHave_reg     <= 1'b0;
      awAddr_reg    <= 12'h000;
      wData_reg     <= 32'h00000000;
      wStrb_reg     <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `AIE_RESP_OKAY;
    end
    else
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      if (s_axi_awvalid && !awHave_reg && !s_axi_awready)
      begin
        s_axi_awready <= 1'b1;
        awHave_reg    <= 1'b1;
        awAddr_reg    <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !wHave_reg && !s_axi_wready)
      begin
        s_axi_wready <= 1'b1;
        wHave_reg    <= 1'b1;
        wData_reg    <= s_axi_wdata;
        wStrb_reg    <= s_axi_wstrb;
      end
      if (doWrite)
      begin
        awHave_reg   <= 1'b0;
        wHave_reg    <= 1'b0;
        s_axi_bvalid <= 1'b1;
        // Unmapped addresses answer SLVERR and change nothing
        s_axi_bresp  <= is_mapped(awAddr_reg) ? `AIE_RESP_OKAY : `AIE_RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // ----------------------------------------
  // Enable and event flag registers
  // ----------------------------------------
  // Next enables from the three views; zero bits leave enables alone in the set and clear views
  always @*
  begin
    irqEnableDirect_next = irqEnableDirect_reg;
    if (doWrite)
    begin
      case (awAddr_reg)
        `AIE_OFF_DIRECT:
          irqEnableDirect_next = directMerged[N-1:0];
        `AIE_OFF_SET:
          irqEnableDirect_next = irqEnableDirect_reg | wMasked[N-1:0];
        `AIE_OFF_CLEAR:
          irqEnableDirect_next = irqEnableDirect_reg & ~wMasked[N-1:0];
        default:
          irqEnableDirect_next = irqEnableDirect_reg;
      endcase
    end
  end

  // Sticky flags: an arriving event wins over a same-cycle write-one clear
  // so software never loses an event that lands while it clears the flags
  always @*
  begin
    eventFlag_next = eventFlag_reg;
    if (doWrite && awAddr_reg == `AIE_OFF_EVENTS)
      eventFlag_next = eventFlag_reg & ~wMasked[N-1:0];
    eventFlag_next = eventFlag_next | eventPulse;
  end

  // Enable, flag and limit storage
  // Limits reset to the ends of the signed range, the widest window
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      irqEnableDirect_reg <= `AIE_ENABLE_RESET;
      eventFlag_reg       <= {N{1'b0}};
      for (i = 0; i < NCH; i = i + 1)
        limit_reg[i] <= `AIE_LIMIT_RESET;
    end
    else
    begin
      irqEnableDirect_reg <= irqEnableDirect_next;
      eventFlag_reg       <= eventFlag_next;
      if (doWrite && limitWrIdx < NCH)
        limit_reg[limitWrIdx[2:0]] <=
          apply_strobe(limit_reg[limitWrIdx[2:0]], wData_reg, wStrb_reg);
    end
  end

  // ----------------------------------------
  // Interrupt output
  // ----------------------------------------
  // Registered so the output comes straight from a flip-flop
  // Taken from next-state values so it moves in step with flags and enables
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      irq <= 1'b0;
    else
      irq <= |(eventFlag_next & irqEnableDirect_next);
  end

  // ----------------------------------------
  // Read channel
  // ----------------------------------------
  // Limit register index for the address on offer
  assign limitRdIdx = limit_index(s_axi_araddr);

  // Read decode; all three enable views return the same state
  always @*
  begin
    readData = 32'h00000000;
    readOk   = 1'b1;
    case (s_axi_araddr)
      `AIE_OFF_DIRECT: readData = {10'h000, irqEnableDirect_reg};
      `AIE_OFF_SET:    readData = {10'h000, irqEnableDirect_reg};
      `AIE_OFF_CLEAR:  readData = {10'h000, irqEnableDirect_reg};
      `AIE_OFF_EVENTS: readData = {10'h000, eventFlag_reg};
      default:
      begin
        if (limitRdIdx < NCH)
          readData = limit_reg[limitRdIdx[2:0]];
        else
          readOk = 1'b0;
      end
    endcase
  end

  // One read at a time; address accepted and data returned next cycle
  // Data is latched with the address, so a later enable write cannot tear it
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `AIE_RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= 1'b0;
      if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid)
      begin
        s_axi_arready <= 1'b1;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= readData;
        s_axi_rresp   <= readOk ? `AIE_RESP_OKAY : `AIE_RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// File: verif/aie_bank_monitor.sv
// Bus and interrupt checker for the enable bank.
// Assumes binding to aie_enable_bank.
`timescale 1ns/1ps
`default_nettype none
`include "aie_consts.vh"

module aie_bank_monitor
(
  // Clock and reset
  input wire logic        clk,
  input wire logic        reset_n,
  // Bus signals
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  // Interrupt
  input wire logic        irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  property p_aw_pulse; s_axi_awready |=> !s_axi_awready; endproperty
  a_aw_pulse: assert property (p_aw_pulse) else $error("awready held");
  property p_w_pulse; s_axi_wready |=> !s_axi_wready; endproperty
  a_w_pulse: assert property (p_w_pulse) else $error("wready held");
  property p_b_after; s_axi_awready && s_axi_wready |=> s_axi_bvalid; endproperty
  a_b_after: assert property (p_b_after) else $error("no write response");
  property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  property p_ar_answer; s_axi_arvalid && !s_axi_arready && !s_axi_rvalid |=> s_axi_arready;
  endproperty
  a_ar_answer: assert property (p_ar_answer) else $error("read address not taken");
  property p_r_with_ar; s_axi_arready |-> s_axi_rvalid; endproperty
  a_r_with_ar: assert property (p_r_with_ar) else $error("read data late");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data changed");
  property p_err_zero; s_axi_rvalid && s_axi_rresp == `AIE_RESP_SLVERR |-> s_axi_rdata == 0;
  endproperty
  a_err_zero: assert property (p_err_zero) else $error("error read not zero");
  property p_reset_idle; $rose(reset_n) |-> !irq && !s_axi_bvalid && !s_axi_rvalid; endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("busy after reset");
  // Main scenarios seen
  c_irq: cover property ($rose(irq));
  c_err: cover property (s_axi_bvalid && s_axi_bresp == `AIE_RESP_SLVERR);
  c_read: cover property (s_axi_rvalid && s_axi_rready);
endmodule

bind aie_enable_bank aie_bank_monitor u_monitor
(
  .clk(clk),
  .reset_n(reset_n),
  .s_axi_awready(s_axi_awready),
  .s_axi_wready(s_axi_wready),
  .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready),
  .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready),
  .s_axi_bresp(s_axi_bresp),
  .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready),
  .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp),
  .irq(irq)
);
`default_nettype wire

// File: verif/aie_event_source.sv
// Model of the converter sequencer feeding event pulses.
// Assumes requests from the bench, one cycle each.
`timescale 1ns/1ps
`default_nettype none

module aie_event_source
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // Requests
  input  wire logic [5:0]  seqReq,
  input  wire logic        resReq,
  input  wire logic [2:0]  resChReq,
  input  wire logic [15:0] resValReq,
  // Pulses to the bank
  output var logic  [5:0]  seqEvent,
  output var logic         resultValid,
  output var logic  [2:0]  resultChannel,
  output var logic  [15:0] resultValue
);
  // Flop stage; result lines scramble between strobes so stale data never helps
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      seqEvent <= 0;
      resultValid <= 0;
      resultChannel <= 0;
      resultValue <= 0;
    end
    else
    begin
      seqEvent <= seqReq;
      resultValid <= resReq;
      resultChannel <= resReq ? resChReq : ~resultChannel;
      resultValue <= resReq ? resValReq : ~resultValue;
    end
  end
endmodule
`default_nettype wire

// File: verif/adc_interrupt_enable_bank_bench.sv
// Self-checking bench for the enable bank.
// Assumes the bound checker and the event source model.
`timescale 1ns/1ps
`default_nettype none
`include "aie_consts.vh"

module adc_interrupt_enable_bank_bench;
  logic        clk = 0, reset_n = 0;
  logic [11:0] awAddr = 0, arAddr = 0;
  logic [31:0] wData = 0, rData;
  logic        awValid = 0, wValid = 0, bReady = 0, arValid = 0, rReady = 0, resReq = 0;
  logic [5:0]  seqReq = 0, seqEvent;
  logic [2:0]  resChReq = 0, resultChannel;
  logic [15:0] resValReq = 0, resultValue;
  logic        awReady, wReady, bValid, arReady, rValid, irq, resultValid;
  logic [1:0]  bResp, rResp;
  int          mismatches = 0, samplesChecked = 0, cycles = 0, i;

  // 200 MHz clock and hang guard
  always #2.5 clk = ~clk;
  always @(posedge clk) if (++cycles == 5000) begin mismatches++; conclude; end

  aie_event_source src (.clk(clk), .reset_n(reset_n), .seqReq(seqReq), .resReq(resReq),
    .resChReq(resChReq), .resValReq(resValReq), .seqEvent(seqEvent),
    .resultValid(resultValid), .resultChannel(resultChannel), .resultValue(resultValue));
  aie_enable_bank dut (.clk(clk), .reset_n(reset_n), .s_axi_awaddr(awAddr),
    .s_axi_awvalid(awValid), .s_axi_awready(awReady), .s_axi_wdata(wData),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp),
    .s_axi_bvalid(bValid), .s_axi_bready(bReady), .s_axi_araddr(arAddr),
    .s_axi_arvalid(arValid), .s_axi_arready(arReady), .s_axi_rdata(rData),
    .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
    .startedEvent(seqEvent[0]), .bufferEndEvent(seqEvent[1]),
    .conversionDoneEvent(seqEvent[2]), .resultReadyEvent(seqEvent[3]),
    .calibrationCompleteEvent(seqEvent[4]), .stoppedEvent(seqEvent[5]),
    .resultValid(resultValid), .resultChannel(resultChannel), .resultValue(resultValue),
    .irq(irq));

  // ----------------------------------------
  // Access tasks
  // ----------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, got);
    samplesChecked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Address and data offered together, each dropped once taken
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    logic awDone = 0, wDone = 0;
    @(posedge clk);
    awAddr <= a;
    wData <= d;
    awValid <= 1;
    wValid <= 1;
    bReady <= 1;
    do
    begin
      @(posedge clk);
      awDone |= awReady;
      wDone |= wReady;
      awValid <= !awDone;
      wValid <= !wDone;
    end while (!bValid);
    bReady <= 0;
    chk("bresp", er, bResp);
  endtask

  task automatic rd(input logic [11:0] a, input logic [1:0] er, input logic [31:0] ed);
    @(posedge clk);
    arAddr <= a;
    arValid <= 1;
    rReady <= 1;
    do
    begin
      @(posedge clk);
      arValid <= arValid && !arReady;
    end while (!rValid);
    rReady <= 0;
    chk("rresp", er, rResp);
    chk($sformatf("rdata %h", a), ed, rData);
  endtask

  // One request to the event source, then let flags and irq settle
  task automatic ev(input logic [5:0] s, input logic v, input logic [2:0] c,
    input logic [15:0] x, input logic expIrq);
    @(posedge clk);
    seqReq <= s;
    resReq <= v;
    resChReq <= c;
    resValReq <= x;
    @(posedge clk);
    seqReq <= 0;
    resReq <= 0;
    repeat (4) @(posedge clk);
    chk("irq", {31'b0, expIrq}, {31'b0, irq});
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", samplesChecked, mismatches);
    if (mismatches == 0 && samplesChecked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial
  begin
    repeat (5) @(posedge clk);
    reset_n <= 1;
    rd(`AIE_OFF_DIRECT, `AIE_RESP_OKAY, 32'h00000000);
    rd(`AIE_OFF_SET, `AIE_RESP_OKAY, 32'h00000000);
    rd(`AIE_OFF_CLEAR, `AIE_RESP_OKAY, 32'h00000000);
    wr(`AIE_OFF_DIRECT, 32'hffffffff, `AIE_RESP_OKAY);
    rd(`AIE_OFF_SET, `AIE_RESP_OKAY, 32'h003fffff);
    wr(`AIE_OFF_CLEAR, 32'h00000002, `AIE_RESP_OKAY);
    rd(`AIE_OFF_CLEAR, `AIE_RESP_OKAY, 32'h003ffffd);
    wr(`AIE_OFF_DIRECT, 32'h00000000, `AIE_RESP_OKAY);
    wr(`AIE_OFF_SET, 32'h00000010, `AIE_RESP_OKAY);
    wr(`AIE_OFF_SET, 32'h00000000, `AIE_RESP_OKAY);
    rd(`AIE_OFF_DIRECT, `AIE_RESP_OKAY, 32'h00000010);
    wr(12'h200, 32'hffffffff, `AIE_RESP_SLVERR);
    rd(12'h200, `AIE_RESP_SLVERR, 32'h00000000);
    // Each sequencing enable passes only its own event
    for (i = 0; i < 6; i++)
    begin
      wr(`AIE_OFF_DIRECT, 32'h1 << i, `AIE_RESP_OKAY);
      ev(~(6'h1 << i), 0, 0, 0, 0);
      ev(6'h1 << i, 0, 0, 0, 1);
      wr(`AIE_OFF_EVENTS, 32'hffffffff, `AIE_RESP_OKAY);
    end
    // Limit enables: at the opposite limit first, then at its own
    for (i = 0; i < 16; i++)
    begin
      wr(`AIE_OFF_DIRECT, 32'h40 << i, `AIE_RESP_OKAY);
      ev(0, 1, i / 2, i % 2 ? 16'h7fff : 16'h8000, 0);
      ev(0, 1, i / 2, i % 2 ? 16'h8000 : 16'h7fff, 1);
      wr(`AIE_OFF_EVENTS, 32'hffffffff, `AIE_RESP_OKAY);
    end
    // Mid-run reset with an enabled flag pending must clear every view and irq
    wr(`AIE_OFF_SET, 32'h00000001, `AIE_RESP_OKAY);
    ev(6'h01, 0, 0, 0, 1);
    @(posedge clk);
    reset_n <= 0;
    repeat (5) @(posedge clk);
    reset_n <= 1;
    rd(`AIE_OFF_DIRECT, `AIE_RESP_OKAY, 32'h00000000);
    rd(`AIE_OFF_SET, `AIE_RESP_OKAY, 32'h00000000);
    rd(`AIE_OFF_CLEAR, `AIE_RESP_OKAY, 32'h00000000);
    rd(`AIE_OFF_EVENTS, `AIE_RESP_OKAY, 32'h00000000);
    chk("irq", 32'h00000000, {31'b0, irq});
    conclude;
  end
endmodule
`default_nettype wire
